// ### design/system_clock_power_modes.sv
// system clock selection, divider, glitch-free switch and low-power mode control
// assumes the core clock is the fast rc clock; slow clocks and oscillator ready
// levels arrive asynchronously and are synchronised here; halt/wake come from the core
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - select code picks fast divide or slow
// - source bit picks slow rc or crystal
// - fast mode runs divided fast rc clock
// - slow mode gates fast clock by enable
// - halt keep 00 sleeps, rc needs watchdog
// - halt keep 01 keeps only slow clock
// - halt keep 11 keeps both clocks
// - halt keep 10 keeps only fast clock
// - fast keep bit holds fast clock in halt
// - slow keep bit holds slow clock in halt
// - fast stable flag clears, then sets
// - fast enable runs rc, resets to one
// - crystal stable flag clears, then sets
// - crystal enable runs crystal, resets zero
// - quick start bit drives crystal startup mode
// - quick start frozen while crystal is the selected system clock
// - switch after four current periods plus alignment
// - unimplemented bits read as zero
module system_clock_power_modes
  import clk_pm_pkg::*;
#(
  parameter int DIV_W = 6 // divider depth, largest ratio 2**DIV_W
) (
  input wire logic core_clk_i, // fast rc clock
  input wire logic rst_n_i, // power-on reset
  input wire logic [1:0] reg_addr_i, // register index
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic halt_i, // core executed halt
  input wire logic wake_i, // wake-up event
  input wire logic wdt_enable_i, // watchdog enabled, async
  input wire logic fast_osc_ready_i, // fast rc settled, async
  input wire logic crystal_ready_i, // crystal settled, async
  input wire logic slow_rc_clk_i, // slow rc clock, async
  input wire logic crystal_clk_i, // watch crystal clock, async
  output logic sys_clk_tick_o, // one pulse per system clock period
  output logic cpu_halted_o, // core clock stopped
  output logic fast_periph_on_o, // fast clock offered to peripherals
  output logic slow_periph_on_o, // slow clock offered to peripherals
  output logic fast_osc_run_o, // fast rc oscillator enable
  output logic slow_rc_run_o, // slow rc oscillator enable
  output logic crystal_run_o, // crystal oscillator enable
  output logic crystal_quick_start_o // crystal high-power startup
);

  // synchroniser: {wdt, fast ready, crystal ready, slow rc clk, crystal clk}
  logic [4:0] sync1_ff; // first stage, read only by the second
  logic [4:0] sync2_ff; // second stage
  logic [1:0] clk_dly_ff; // third stage for clock edge detect
  logic wdt_s;
  logic fast_ready_s;
  logic xtal_ready_s;
  logic rc_edge;
  logic xtal_edge;

  // software registers
  logic [2:0] sel_ff, nxt_sel; // requested clock select
  logic src_ff, nxt_src; // requested slow source
  logic fkeep_ff, nxt_fkeep;
  logic skeep_ff, nxt_skeep;
  logic fen_ff, nxt_fen; // fast oscillator enable
  logic xen_ff, nxt_xen; // crystal enable
  logic qs_ff, nxt_qs; // crystal quick start

  // switch state
  logic [2:0] act_sel_ff, nxt_act_sel; // clock actually driving the system
  logic act_src_ff, nxt_act_src;
  logic busy_ff, nxt_busy;
  logic [2:0] sw_cnt_ff, nxt_sw_cnt; // current-clock periods seen
  logic [DIV_W-1:0] div_ff, nxt_div; // free-running divider

  // mode and oscillator state
  power_mode_t mode_ff, nxt_mode;
  logic fast_run_ff, nxt_fast_run;
  logic rc_run_ff, nxt_rc_run;
  logic xtal_run_ff, nxt_xtal_run;
  logic fast_stable_ff, nxt_fast_stable;
  logic xtal_stable_ff, nxt_xtal_stable;
  logic fper_ff, nxt_fper;
  logic sper_ff, nxt_sper;
  logic halted_ff, nxt_halted;
  logic tick_ff, nxt_tick;
  logic [7:0] rdata_ff, nxt_rdata;

  // tick helpers
  logic cur_tick;
  logic tar_tick;
  logic running;

  // fast tick: divider low bits all zero under the mask of the ratio
  function automatic logic fast_tick(input logic [2:0] sel, input logic [DIV_W-1:0] cnt);
    logic [DIV_W-1:0] mask;
    mask = ~({DIV_W{1'b1}} << sel);
    fast_tick = ((cnt & mask) == '0);
  endfunction : fast_tick

  // slow tick from the chosen source edge
  function automatic logic slow_tick(input logic src, input logic rc_e, input logic xt_e);
    slow_tick = (src == SRC_CRYSTAL) ? xt_e : rc_e;
  endfunction : slow_tick

  // two flops before any logic; clocks get one more for edges
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      clk_dly_ff <= 2'h0;
    end else begin
      sync1_ff <= {wdt_enable_i, fast_osc_ready_i, crystal_ready_i,
                   slow_rc_clk_i, crystal_clk_i};
      sync2_ff <= sync1_ff;
      clk_dly_ff <= sync2_ff[1:0];
    end
  end

  assign wdt_s = sync2_ff[4];
  assign fast_ready_s = sync2_ff[3];
  assign xtal_ready_s = sync2_ff[2];
  assign rc_edge = sync2_ff[1] & ~clk_dly_ff[1];
  assign xtal_edge = sync2_ff[0] & ~clk_dly_ff[0];

  // register writes
  always_comb begin
    nxt_sel = sel_ff;
    nxt_src = src_ff;
    nxt_fkeep = fkeep_ff;
    nxt_skeep = skeep_ff;
    nxt_fen = fen_ff;
    nxt_xen = xen_ff;
    nxt_qs = qs_ff;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_SYS: begin
          nxt_sel = reg_wdata_i[SYSC_SEL_MSB:SYSC_SEL_LSB];
          nxt_src = reg_wdata_i[SYSC_SRC_BIT];
          nxt_fkeep = reg_wdata_i[SYSC_FKEEP_BIT];
          nxt_skeep = reg_wdata_i[SYSC_SKEEP_BIT];
        end
        ADDR_FRC: begin
          nxt_fen = reg_wdata_i[FRC_EN_BIT];
        end
        ADDR_WXC: begin
          nxt_xen = reg_wdata_i[WXC_EN_BIT];
          // mode is locked while the crystal is the requested system clock (sel_ff and src_ff)
          if (!(sel_ff == SEL_SLOW && src_ff == SRC_CRYSTAL)) begin
            nxt_qs = reg_wdata_i[WXC_QS_BIT];
          end
        end
        default: begin
          // status register and stable flags ignore writes
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_ff <= SEL_RST;
      src_ff <= SRC_RST;
      fkeep_ff <= KEEP_RST;
      skeep_ff <= KEEP_RST;
      fen_ff <= FAST_EN_RST;
      xen_ff <= XTAL_EN_RST;
      qs_ff <= QS_RST;
    end else begin
      sel_ff <= nxt_sel;
      src_ff <= nxt_src;
      fkeep_ff <= nxt_fkeep;
      skeep_ff <= nxt_skeep;
      fen_ff <= nxt_fen;
      xen_ff <= nxt_xen;
      qs_ff <= nxt_qs;
    end
  end

  // current and target clock ticks; ticks are single pulses so muxing is glitch free
  always_comb begin
    cur_tick = (act_sel_ff == SEL_SLOW) ? slow_tick(act_src_ff, rc_edge, xtal_edge)
                                        : fast_tick(act_sel_ff, div_ff);
    tar_tick = (sel_ff == SEL_SLOW) ? slow_tick(src_ff, rc_edge, xtal_edge)
                                    : fast_tick(sel_ff, div_ff);
    running = (mode_ff == RUN_FAST) || (mode_ff == RUN_SLOW);
  end

  // switch: count current periods, then hand over on a target edge
  always_comb begin
    nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
    nxt_act_sel = act_sel_ff;
    nxt_act_src = act_src_ff;
    nxt_busy = busy_ff;
    nxt_sw_cnt = sw_cnt_ff;
    // next mode gates the tick so no tick escapes on the halt edge
    nxt_tick = (nxt_mode == RUN_FAST || nxt_mode == RUN_SLOW) && cur_tick;
    if (!busy_ff) begin
      if (sel_ff != act_sel_ff || src_ff != act_src_ff) begin
        nxt_busy = 1'b1;
        nxt_sw_cnt = 3'h0;
      end
    end else if (sw_cnt_ff != SWITCH_CUR_TICKS) begin
      if (cur_tick) begin
        nxt_sw_cnt = sw_cnt_ff + 3'h1;
      end
    end else if (tar_tick) begin
      // hand over exactly on the target edge, no runt pulse
      nxt_act_sel = sel_ff;
      nxt_act_src = src_ff;
      nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= '0;
      act_sel_ff <= SEL_RST;
      act_src_ff <= SRC_RST;
      busy_ff <= 1'b0;
      sw_cnt_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      act_sel_ff <= nxt_act_sel;
      act_src_ff <= nxt_act_src;
      busy_ff <= nxt_busy;
      sw_cnt_ff <= nxt_sw_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // power mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      RUN_FAST, RUN_SLOW: begin
        if (halt_i) begin
          case ({fkeep_ff, skeep_ff})
            2'b00: nxt_mode = SLEEP;
            2'b01: nxt_mode = IDLE_SLOW_ONLY;
            2'b11: nxt_mode = IDLE_BOTH_CLOCKS;
            default: nxt_mode = IDLE_FAST_ONLY;
          endcase
        end else begin
          nxt_mode = (act_sel_ff == SEL_SLOW) ? RUN_SLOW : RUN_FAST;
        end
      end
      SLEEP, IDLE_SLOW_ONLY, IDLE_BOTH_CLOCKS, IDLE_FAST_ONLY: begin
        if (wake_i) begin
          nxt_mode = (act_sel_ff == SEL_SLOW) ? RUN_SLOW : RUN_FAST;
        end
      end
      default: nxt_mode = RUN_FAST;
    endcase
  end

  // oscillator enables, peripheral clocks and stable flags follow the next mode
  always_comb begin
    nxt_halted = 1'b1;
    nxt_fper = 1'b0;
    nxt_sper = 1'b0;
    nxt_fast_run = 1'b0;
    nxt_rc_run = 1'b1;
    case (nxt_mode)
      RUN_FAST: begin
        nxt_halted = 1'b0;
        nxt_fper = 1'b1;
        nxt_sper = 1'b1;
        nxt_fast_run = 1'b1;
      end
      RUN_SLOW: begin
        nxt_halted = 1'b0;
        nxt_fper = fen_ff;
        nxt_sper = 1'b1;
        nxt_fast_run = fen_ff;
      end
      SLEEP: begin
        nxt_rc_run = wdt_s;
      end
      IDLE_SLOW_ONLY: begin
        nxt_sper = 1'b1;
      end
      IDLE_BOTH_CLOCKS: begin
        nxt_fper = 1'b1;
        nxt_sper = 1'b1;
        nxt_fast_run = 1'b1;
      end
      IDLE_FAST_ONLY: begin
        nxt_fper = 1'b1;
        nxt_fast_run = 1'b1;
      end
      default: begin
        nxt_halted = 1'b0;
      end
    endcase
    // crystal runs while enabled unless the slow clock is stopped by halt
    nxt_xtal_run = xen_ff && (nxt_sper || !nxt_halted);
    // a fresh start clears the flag even if ready is still high
    if (nxt_fast_run && !fast_run_ff) begin
      nxt_fast_stable = 1'b0;
    end else begin
      nxt_fast_stable = nxt_fast_run && (fast_stable_ff || fast_ready_s);
    end
    if (nxt_xtal_run && !xtal_run_ff) begin
      nxt_xtal_stable = 1'b0;
    end else begin
      nxt_xtal_stable = nxt_xtal_run && (xtal_stable_ff || xtal_ready_s);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= RUN_FAST;
      halted_ff <= 1'b0;
      fper_ff <= 1'b1;
      sper_ff <= 1'b1;
      fast_run_ff <= 1'b1;
      rc_run_ff <= 1'b1;
      xtal_run_ff <= 1'b0;
      fast_stable_ff <= 1'b0;
      xtal_stable_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      halted_ff <= nxt_halted;
      fper_ff <= nxt_fper;
      sper_ff <= nxt_sper;
      fast_run_ff <= nxt_fast_run;
      rc_run_ff <= nxt_rc_run;
      xtal_run_ff <= nxt_xtal_run;
      fast_stable_ff <= nxt_fast_stable;
      xtal_stable_ff <= nxt_xtal_stable;
    end
  end

  // read data, one cycle after the strobe; holes read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_SYS: begin
          nxt_rdata[SYSC_SEL_MSB:SYSC_SEL_LSB] = sel_ff;
          nxt_rdata[SYSC_SRC_BIT] = src_ff;
          nxt_rdata[SYSC_FKEEP_BIT] = fkeep_ff;
          nxt_rdata[SYSC_SKEEP_BIT] = skeep_ff;
        end
        ADDR_FRC: begin
          nxt_rdata[FRC_STABLE_BIT] = fast_stable_ff;
          nxt_rdata[FRC_EN_BIT] = fen_ff;
        end
        ADDR_WXC: begin
          nxt_rdata[WXC_QS_BIT] = qs_ff;
          nxt_rdata[WXC_STABLE_BIT] = xtal_stable_ff;
          nxt_rdata[WXC_EN_BIT] = xen_ff;
        end
        default: begin
          nxt_rdata[STAT_BUSY_BIT] = busy_ff;
          nxt_rdata[STAT_SLOW_BIT] = (act_sel_ff == SEL_SLOW);
          nxt_rdata[STAT_HALT_BIT] = halted_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign sys_clk_tick_o = tick_ff;
  assign cpu_halted_o = halted_ff;
  assign fast_periph_on_o = fper_ff;
  assign slow_periph_on_o = sper_ff;
  assign fast_osc_run_o = fast_run_ff;
  assign slow_rc_run_o = rc_run_ff;
  assign crystal_run_o = xtal_run_ff;
  assign crystal_quick_start_o = qs_ff;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence halt_keep_s(logic [1:0] k);
    running && halt_i && {fkeep_ff, skeep_ff} == k;
  endsequence

  AST_UNDIVIDED: assert property ((mode_ff == RUN_FAST && act_sel_ff == 3'h0 && !halt_i)
    |=> sys_clk_tick_o) else $error("undivided fast clock missed a tick");
  AST_SLOW_SRC: assert property ((running && act_sel_ff == SEL_SLOW
    && act_src_ff == SRC_CRYSTAL && !xtal_edge) |=> !sys_clk_tick_o)
    else $error("slow tick without crystal edge");
  AST_DIV64: assert property ((sys_clk_tick_o && act_sel_ff == 3'h6)
    |=> !sys_clk_tick_o [*8]) else $error("divide by 64 ticks too close");
  AST_SLOW_FAST_EN: assert property ((mode_ff == RUN_SLOW && $stable(mode_ff))
    |-> fast_osc_run_o == $past(fen_ff)) else $error("slow mode fast enable wrong");
  AST_SLEEP: assert property (halt_keep_s(2'b00) |=> mode_ff == SLEEP
    ##0 !slow_periph_on_o && !fast_periph_on_o && cpu_halted_o)
    else $error("sleep entry wrong");
  AST_IDLE_SLOW: assert property (halt_keep_s(2'b01) |=> mode_ff == IDLE_SLOW_ONLY
    && slow_periph_on_o && !fast_osc_run_o) else $error("idle slow entry wrong");
  AST_IDLE_BOTH: assert property (halt_keep_s(2'b11) |=> fast_osc_run_o
    && slow_periph_on_o && fast_periph_on_o) else $error("idle both entry wrong");
  AST_IDLE_FAST: assert property (halt_keep_s(2'b10) |=> fast_osc_run_o
    && !slow_periph_on_o && cpu_halted_o) else $error("idle fast entry wrong");
  AST_FAST_STABLE: assert property ($rose(fast_osc_run_o) |-> !fast_stable_ff)
    else $error("fast stable not cleared on start");
  AST_XTAL_STABLE: assert property ($rose(crystal_run_o) |-> !xtal_stable_ff)
    else $error("crystal stable not cleared on start");
  AST_QS_HOLD: assert property ((sel_ff == SEL_SLOW && src_ff == SRC_CRYSTAL)
    |=> $stable(qs_ff)) else $error("quick start changed while locked");
  AST_SWITCH: assert property ((act_sel_ff != $past(act_sel_ff))
    |-> $past(sw_cnt_ff) == SWITCH_CUR_TICKS) else $error("switch too early");
  AST_HOLES: assert property ($past(reg_rd_i && reg_addr_i == ADDR_SYS)
    |-> reg_rdata_o[4:3] == 2'h0) else $error("unimplemented bits not zero");

endmodule : system_clock_power_modes

`default_nettype wire

// ### design/clk_pm_pkg.sv
// constants, register map and mode type for the system clock and power mode block
// assumes a single core clock; oscillators sit outside and only send their clocks and ready levels
package clk_pm_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] ADDR_SYS = 2'h0; // system_clock_control
  localparam logic [1:0] ADDR_FRC = 2'h1; // fast_rc_control
  localparam logic [1:0] ADDR_WXC = 2'h2; // watch_crystal_control
  localparam logic [1:0] ADDR_STAT = 2'h3; // power status, read only
  // system_clock_control fields
  localparam int SYSC_SEL_LSB = 5;
  localparam int SYSC_SEL_MSB = 7;
  localparam int SYSC_SRC_BIT = 2;
  localparam int SYSC_FKEEP_BIT = 1;
  localparam int SYSC_SKEEP_BIT = 0;
  // fast_rc_control fields
  localparam int FRC_STABLE_BIT = 1;
  localparam int FRC_EN_BIT = 0;
  // watch_crystal_control fields
  localparam int WXC_QS_BIT = 2;
  localparam int WXC_STABLE_BIT = 1;
  localparam int WXC_EN_BIT = 0;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SLOW_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  // reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic SRC_RST = 1'b0;
  localparam logic KEEP_RST = 1'b0;
  localparam logic FAST_EN_RST = 1'b1;
  localparam logic XTAL_EN_RST = 1'b0;
  localparam logic QS_RST = 1'b0;
  // clock select codes
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic SRC_SLOW_RC = 1'b0;
  localparam logic SRC_CRYSTAL = 1'b1;
  // switch delay: whole periods of the current clock before the hand-over
  localparam logic [2:0] SWITCH_CUR_TICKS = 3'h4;
  // power modes
  typedef enum logic [2:0] {
    RUN_FAST,
    RUN_SLOW,
    SLEEP,
    IDLE_SLOW_ONLY,
    IDLE_BOTH_CLOCKS,
    IDLE_FAST_ONLY
  } power_mode_t;
endpackage : clk_pm_pkg

// ### verification/core_model.sv
// processor core model: register port master plus halt and wake pulses
// assumes one clock domain shared with the block; no waits from the slave
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clk_i, // core clock
  input wire logic [7:0] rdata_i, // read data from the block
  output logic [1:0] addr_o, // register index
  output logic [7:0] wdata_o, // write data
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  output logic halt_o, // halt pulse
  output logic wake_o // wake pulse
);
  initial begin
    addr_o = 2'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    halt_o = 1'b0;
    wake_o = 1'b0;
  end
  // one-cycle write; data flipped afterwards so stale data never looks valid
  task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : write_reg
  // one-cycle read; data stands only in the cycle after the strobe
  task automatic read_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : read_reg
  // pulse halt or wake for exactly one cycle
  task automatic pulse(input bit is_wake);
    @(posedge clk_i);
    if (is_wake) wake_o <= 1'b1;
    else halt_o <= 1'b1;
    @(posedge clk_i);
    wake_o <= 1'b0;
    halt_o <= 1'b0;
  endtask : pulse
  // software must not lean on the fast clock before its stable flag
  task automatic wait_fast_stable(output bit ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      read_reg(2'h1, d);
      ok = (d[1] === 1'b1);
    end
  endtask : wait_fast_stable
  // poll the switch busy bit; cycles spent, or -1 when it never cleared
  task automatic wait_switch(output int cyc);
    logic [7:0] d;
    cyc = -1;
    for (int i = 0; i < 200 && cyc < 0; i++) begin
      read_reg(2'h3, d);
      if (d[0] === 1'b0) cyc = 2 * i + 3;
    end
  endtask : wait_switch
endmodule : core_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the system clock and power mode block
// assumes the core model in its own file; oscillator clocks run free here
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import clk_pm_pkg::*;
  logic core_clk = 1'b0; // 25 MHz core clock
  logic rst_n = 1'b0; // power-on reset, low
  logic wdt_en = 1'b0; // watchdog level
  logic fast_rdy = 1'b1; // fast rc settled
  logic xtal_rdy = 1'b0; // crystal settled
  logic rc_clk = 1'b0; // slow rc, 20 core periods
  logic xtal_clk = 1'b0; // crystal, 12 core periods
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, halt, wake;
  logic tick, halted, fper, sper, frun, rcrun, xrun, qs;
  int err_total = 0;
  int n_tests = 0;
  int tick_cnt = 0;
  always #20 core_clk = ~core_clk;
  always #400 rc_clk = ~rc_clk;
  // odd start offset keeps the crystal out of phase with the core clock
  initial begin
    #7;
    forever #240 xtal_clk = ~xtal_clk;
  end
  // running count of system clock ticks
  always @(posedge core_clk) begin
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
  end
  system_clock_power_modes #(.DIV_W(6)) i_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .halt_i(halt), .wake_i(wake),
    .wdt_enable_i(wdt_en), .fast_osc_ready_i(fast_rdy), .crystal_ready_i(xtal_rdy),
    .slow_rc_clk_i(rc_clk), .crystal_clk_i(xtal_clk), .sys_clk_tick_o(tick),
    .cpu_halted_o(halted), .fast_periph_on_o(fper), .slow_periph_on_o(sper),
    .fast_osc_run_o(frun), .slow_rc_run_o(rcrun), .crystal_run_o(xrun),
    .crystal_quick_start_o(qs)
  );
  core_model i_core (
    .clk_i(core_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .halt_o(halt), .wake_o(wake)
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : check
  // write select and wait until the hand-over, within a loose bound
  task automatic switch_to(input logic [7:0] v, input int bound);
    int cyc;
    i_core.write_reg(ADDR_SYS, v);
    i_core.wait_switch(cyc);
    if (cyc < 0) begin
      $display("wrong value switch busy expected 0 seen 1");
      err_total++;
      end_of_test();
    end
    check("switch time", 8'(cyc <= bound), 8'h01);
  endtask : switch_to
  // cycles between two consecutive ticks
  task automatic tick_gap(output int g);
    int t0;
    t0 = -1;
    g = 0;
    for (int i = 0; i < 300 && g == 0; i++) begin
      @(posedge core_clk);
      #1;
      if (tick === 1'b1 && t0 >= 0) g = i - t0;
      else if (tick === 1'b1) t0 = i;
    end
  endtask : tick_gap
  // ticks counted in a window, compared with an expected count +-1
  task automatic tick_window(input int cycles, input int exp, input string what);
    int n0;
    n0 = tick_cnt;
    repeat (cycles) @(posedge core_clk);
    check(what, 8'((tick_cnt - n0 >= exp - 1) && (tick_cnt - n0 <= exp + 1)), 8'h01);
  endtask : tick_window
  task automatic t_reset();
    check("fast run", 8'(frun), 8'h01);
    check("crystal run", 8'(xrun), 8'h00);
    i_core.read_reg(ADDR_SYS, d);
    check("sys ctrl", d, 8'h00);
    i_core.read_reg(ADDR_FRC, d);
    check("frc", d, 8'h03);
    i_core.read_reg(ADDR_WXC, d);
    check("wxc", d, 8'h00);
    // reserved bits and the read-only flag ignore writes
    i_core.write_reg(ADDR_SYS, 8'h18);
    i_core.read_reg(ADDR_SYS, d);
    check("sys ctrl reserved", d, 8'h00);
    i_core.write_reg(ADDR_FRC, 8'hfd);
    i_core.read_reg(ADDR_FRC, d);
    check("frc reserved", d, 8'h03);
  endtask : t_reset
  // every fast divide code, walking the ratio up then back to one
  task automatic t_divide();
    int g;
    tick_gap(g);
    check("gap div1", 8'(g), 8'h01);
    for (int s = 1; s < 7; s++) begin
      switch_to({3'(s), 5'h00}, 6 * (1 << (s - 1)) + (1 << s) + 8);
      tick_gap(g);
      check("gap div", 8'(g), 8'(1 << s));
    end
    switch_to(8'h00, 6 * 64 + 9);
  endtask : t_divide
  task automatic t_crystal();
    i_core.write_reg(ADDR_WXC, 8'h05);
    i_core.read_reg(ADDR_WXC, d);
    check("wxc start", d, 8'h05);
    check("crystal run", 8'(xrun), 8'h01);
    check("quick start", 8'(qs), 8'h01);
    @(posedge core_clk) xtal_rdy <= 1'b1;
    repeat (6) @(posedge core_clk);
    i_core.read_reg(ADDR_WXC, d);
    check("wxc stable", d, 8'h07);
    i_core.write_reg(ADDR_WXC, 8'h05);
    i_core.read_reg(ADDR_WXC, d);
    check("wxc flag kept", d, 8'h07);
  endtask : t_crystal
  task automatic t_slow();
    bit ok;
    switch_to(8'he0, 6 + 20 + 12);
    i_core.read_reg(ADDR_STAT, d);
    check("slow active", 8'(d[STAT_SLOW_BIT]), 8'h01);
    tick_window(200, 10, "rc ticks");
    // slow mode lets the enable bit stop the fast rc
    i_core.write_reg(ADDR_FRC, 8'h00);
    @(posedge core_clk) fast_rdy <= 1'b0;
    #1;
    check("fast off", 8'(frun), 8'h00);
    i_core.write_reg(ADDR_FRC, 8'h01);
    i_core.read_reg(ADDR_FRC, d);
    check("frc restart", d, 8'h01);
    check("fast on", 8'(frun), 8'h01);
    @(posedge core_clk) fast_rdy <= 1'b1;
    i_core.wait_fast_stable(ok);
    check("fast stable", 8'(ok), 8'h01);
    switch_to(8'he4, 6 * 20 + 24);
    tick_window(240, 20, "crystal ticks");
    // quick start is frozen while the crystal is the selected system clock
    i_core.write_reg(ADDR_WXC, 8'h01);
    i_core.read_reg(ADDR_WXC, d);
    check("qs locked", d, 8'h07);
    check("qs pin", 8'(qs), 8'h01);
    switch_to(8'h00, 6 * 12 + 12);
    i_core.write_reg(ADDR_WXC, 8'h01);
    i_core.read_reg(ADDR_WXC, d);
    check("qs free", d, 8'h03);
    check("qs pin low", 8'(qs), 8'h00);
  endtask : t_slow
  // all four keep codes, sleep twice to see the watchdog hold the rc
  task automatic t_halt();
    logic [1:0] k;
    int n0;
    for (int i = 0; i < 5; i++) begin
      k = 2'(i);
      i_core.write_reg(ADDR_SYS, {6'h00, k});
      @(posedge core_clk) wdt_en <= (i == 4);
      repeat (4) @(posedge core_clk);
      i_core.pulse(1'b0);
      #1;
      n0 = tick_cnt;
      check("halted", 8'(halted), 8'h01);
      check("fast periph", 8'(fper), 8'(k[1]));
      check("slow periph", 8'(sper), 8'(k[0]));
      check("fast osc", 8'(frun), 8'(k[1]));
      check("slow rc", 8'(rcrun), 8'((k != 2'h0) || (i == 4)));
      repeat (10) @(posedge core_clk);
      check("ticks halted", 8'(tick_cnt - n0), 8'h00);
      i_core.pulse(1'b1);
      #1;
      check("woken", 8'(halted), 8'h00);
    end
  endtask : t_halt
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_divide();
    t_crystal();
    t_slow();
    t_halt();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
